/* fup_defines.vh */
// Constants shared by the serial transceiver with PC-style port decode
//
// Behaviour
// R1 - Receiver uses the external 16X receive clock when that input is chosen.
// R2 - Rate generator pin outputs an active-low 16X clock of the selected rate.
// R3 - PC mode feeds generator clock to receiver; pin becomes printer decode.
// R4 - Bus style select low enables on-chip COM address and IRQ decoding.
// R5 - Drive disable output is low during every host read, high otherwise.
// R6 - Reset of at least 40 ns returns every register and output to default.
// R7 - During reset serial output sits at 1 and serial input is ignored.
// R8 - Transmit frames bytes with start and stop bits; receive rebuilds bytes.
// R9 - With parity enabled a parity bit is sent, checked, mismatch flagged.
// R10 - Separate transmit and receive FIFOs of 32 bytes each.
// R11 - Rate generator has a prescaler dividing by 1 or 4 before the divisor.
// R12 - Serial data sampled at sixteen times bit rate, up to 3.125 Mbps.
// R13 - Each FIFO has four selectable trigger levels raising a service request.
// R14 - Automatic RTS/CTS flow control with hysteresis on request-to-send.
// R15 - Automatic Xon/Xoff flow control plus programmable special character.
// R16 - Infrared encoder on transmit and decoder on receive.
// R17 - Independent transmit and receive rates, sleep mode, modem outputs.
// R18 - PC mode: two tri-state interrupt lines, one open-source shared line.
// R19 - Serial output idles at 1 normally, idles low with high pulses in IR.
// R20 - With auto CTS, transmission stops on CTS deassert, resumes on assert.
// R21 - PC interrupt outputs enabled only with modem control bit 3 set.
// R22 - Least significant bit first, low start, high stop, mid-bit sampling.
// R23 - Start bit confirmed low at mid-bit, else treated as noise.
`ifndef FUP_DEFINES_VH
`define FUP_DEFINES_VH

// Timing
`define FUP_CLK_PERIOD_NS  4
`define FUP_RST_MIN_NS     40
`define FUP_RST_MIN_CYC    ((`FUP_RST_MIN_NS + `FUP_CLK_PERIOD_NS - 1) / `FUP_CLK_PERIOD_NS)
`define FUP_PRESCALE_LAST  2'h3
`define FUP_SAMPLE_LAST    4'hF
`define FUP_SAMPLE_MID     4'h7
`define FUP_IR_PULSE_LEN   4'h3

// FIFOs
`define FUP_FIFO_WIDTH     8
`define FUP_FIFO_DEPTH     32
`define FUP_FIFO_AW        5
`define FUP_RTS_OFF_LVL    6'h1C
`define FUP_RTS_ON_LVL     6'h10
`define FUP_TRIG_L0        6'h08
`define FUP_TRIG_L1        6'h10
`define FUP_TRIG_L2        6'h18
`define FUP_TRIG_L3        6'h1C

// Host register offsets
`define FUP_REG_DATA       3'h0
`define FUP_REG_RXLVL      3'h1
`define FUP_REG_TXLVL      3'h2
`define FUP_REG_STATUS     3'h5

// Status field positions
`define FUP_ST_RX_AVAIL    0
`define FUP_ST_OVERRUN     1
`define FUP_ST_PARITY      2
`define FUP_ST_FRAMING     3
`define FUP_ST_SPECIAL     4
`define FUP_ST_TX_ROOM     5
`define FUP_ST_TX_IDLE     6
`define FUP_ST_XOFF        7

// Modem control field positions
`define FUP_MCR_DTR        0
`define FUP_MCR_RTS        1
`define FUP_MCR_OP1        2
`define FUP_MCR_IRQ_EN     3
`define FUP_MCR_OP2        4
`define FUP_MCR_INT_TYPE   5

// PC port address blocks (address bits 9 to 3)
`define FUP_COM1_BLK       7'h7F
`define FUP_COM2_BLK       7'h5F
`define FUP_COM3_BLK       7'h7D
`define FUP_COM4_BLK       7'h5D
`define FUP_LPT1_BLK       7'h6F

`endif

/* fup_fifo.v */
// Parameterised first-word-fall-through FIFO
`timescale 1ns/1ps
module fup_fifo #(
	parameter W     = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// Clock and reset
	input  wire          clk_in,
	input  wire          arst_n_in,
	// Fill side
	input  wire          in_valid_in,
	input  wire [W-1:0]  in_data_in,
	output wire          in_ready_out,
	// Drain side
	output wire          out_valid_out,
	output wire [W-1:0]  out_data_out,
	input  wire          out_ready_in,
	// Fill level
	output wire [AW:0]   level_out
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wptr_q;
	reg [AW-1:0] rptr_q;
	reg [AW:0]   count_q;
	wire         push;
	wire         pop;

	assign in_ready_out  = (count_q != DEPTH[AW:0]);
	assign out_valid_out = (count_q != {(AW+1){1'b0}});
	assign out_data_out  = mem[rptr_q];
	assign level_out     = count_q;
	assign push = in_valid_in & in_ready_out;
	assign pop  = out_ready_in & out_valid_out;

	always @(posedge clk_in) begin
		if (push)
			mem[wptr_q] <= in_data_in;
	end

	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wptr_q  <= {AW{1'b0}};
			rptr_q  <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wptr_q <= wptr_q + 1'b1;
			if (pop)
				rptr_q <= rptr_q + 1'b1;
			if (push & ~pop)
				count_q <= count_q + 1'b1;
			else if (pop & ~push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule // fup_fifo

/* fup_line_model.sv */
// Far-end serial receiver that rebuilds bytes from the line
`timescale 1ns/1ps
module fup_line_model #(parameter BIT = 32) (
	// Clock and line
	input wire       clk_in,
	input wire       txd_in,
	// Last byte and byte count
	output reg [7:0] byte_out,
	output integer   count_out
);
	integer i;
	initial begin
		byte_out = 8'h00;
		count_out = 0;
		forever begin
			@(negedge txd_in);
			repeat (BIT / 2) @(posedge clk_in);
			// Short glitches are dropped as the receiver does
			if (!txd_in) begin
				for (i = 0; i < 8; i = i + 1) begin
					repeat (BIT) @(posedge clk_in);
					byte_out[i] = txd_in;
				end
				repeat (BIT) @(posedge clk_in);
				count_out = count_out + 1;
			end
		end
	end
endmodule // fup_line_model

/* fup_rate_gen.v */
// Rate generator: prescaler and divisor producing a 16X enable pulse
`timescale 1ns/1ps
`include "fup_defines.vh"
module fup_rate_gen (
	// Clock and reset
	input  wire        clk_in,
	input  wire        arst_n_in,
	// Control
	input  wire        en_in,
	input  wire        prescale4_in,
	input  wire [15:0] divisor_in,
	// 16X enable pulse
	output reg         tick_out
);
	reg  [1:0]  pre_q;
	reg  [15:0] div_q;
	wire        pre_tick;
	wire [15:0] div_last;

	assign pre_tick = en_in & (~prescale4_in | (pre_q == `FUP_PRESCALE_LAST)); // R11
	// A zero divisor would wrap to 65536 counts, so it behaves as one
	assign div_last = (divisor_in == 16'h0000) ? 16'h0000 : divisor_in - 16'h0001;

	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pre_q    <= 2'h0;
			div_q    <= 16'h0000;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (en_in)
				pre_q <= prescale4_in ? pre_q + 2'h1 : 2'h0;
			if (pre_tick) begin
				if (div_q >= div_last) begin
					div_q    <= 16'h0000;
					tick_out <= 1'b1;
				end else begin
					div_q <= div_q + 16'h0001;
				end
			end
		end
	end
endmodule // fup_rate_gen

/* fup_top.v */
// Serial transceiver with FIFOs, flow control, IR coding and PC decode
`timescale 1ns/1ps
`include "fup_defines.vh"
module fup_top (
	// Clock and reset
	input  wire        clk_in,
	input  wire        arst_n_in,
	// Host parallel port
	input  wire        sel_n_in,
	input  wire [2:0]  com_sel_in,
	input  wire [9:0]  addr_in,
	input  wire        cs_n_in,
	input  wire        rd_n_in,
	input  wire        wr_n_in,
	input  wire [7:0]  data_in,
	output reg  [7:0]  data_out,
	output reg         transceiver_drive_disable_n_out,
	// Configuration
	input  wire        parity_en_in,
	input  wire        parity_even_in,
	input  wire        stop2_in,
	input  wire        prescale4_in,
	input  wire [15:0] tx_divisor_in,
	input  wire [15:0] rx_divisor_in,
	input  wire        ext_rx_clk_en_in,
	input  wire        ir_mode_in,
	input  wire        sleep_in,
	input  wire [1:0]  tx_trig_sel_in,
	input  wire [1:0]  rx_trig_sel_in,
	input  wire        irq_tx_en_in,
	input  wire        irq_rx_en_in,
	input  wire [7:0]  modem_control_reg_in,
	// Flow control configuration
	input  wire        auto_cts_en_in,
	input  wire        auto_rts_en_in,
	input  wire        sw_flow_en_in,
	input  wire [7:0]  xon_char_in,
	input  wire [7:0]  xoff_char_in,
	input  wire [7:0]  special_char_in,
	// Serial and modem pins
	input  wire        rxd_in,
	input  wire        rclk_in,
	input  wire        cts_n_in,
	output reg         txd_out,
	output reg         rts_n_out,
	output reg         dtr_n_out,
	output reg         op1_n_out,
	output reg         op2_n_out,
	output reg         rate_gen_clock_out_n_out,
	output reg         tx_full_out,
	// Interrupt lines
	output reg         shared_irq_out,
	output reg         shared_irq_oe_out,
	output reg         com_irq_primary_out,
	output reg         com_irq_primary_oe_out,
	output reg         com_irq_secondary_out,
	output reg         com_irq_secondary_oe_out
);
	localparam T_IDLE  = 3'd0;
	localparam T_START = 3'd1;
	localparam T_DATA  = 3'd2;
	localparam T_PAR   = 3'd3;
	localparam T_STOP  = 3'd4;
	localparam R_IDLE  = 3'd0;
	localparam R_START = 3'd1;
	localparam R_DATA  = 3'd2;
	localparam R_PAR   = 3'd3;
	localparam R_STOP  = 3'd4;

	function [6:0] com_blk;
		input [1:0] s;
		begin
			case (s)
			2'd0: com_blk = `FUP_COM1_BLK;
			2'd1: com_blk = `FUP_COM2_BLK;
			2'd2: com_blk = `FUP_COM3_BLK;
			default: com_blk = `FUP_COM4_BLK;
			endcase
		end
	endfunction

	function [5:0] trig_lvl;
		input [1:0] s;
		begin
			case (s)
			2'd0: trig_lvl = `FUP_TRIG_L0;
			2'd1: trig_lvl = `FUP_TRIG_L1;
			2'd2: trig_lvl = `FUP_TRIG_L2;
			default: trig_lvl = `FUP_TRIG_L3;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Host access decode

	wire       pc_mode;
	wire       hit;
	wire       rd_act;
	wire       wr_act;
	wire       lpt1_hit;
	reg        rd_q;
	reg        wr_q;
	wire       rd_edge;
	wire       wr_edge;

	assign pc_mode = ~sel_n_in;
	assign hit = pc_mode ? (addr_in[9:3] == com_blk(com_sel_in[1:0])) // R4
	                     : ~cs_n_in;
	assign lpt1_hit = (addr_in[9:3] == `FUP_LPT1_BLK);
	assign rd_act  = hit & ~rd_n_in;
	assign wr_act  = hit & ~wr_n_in;
	assign rd_edge = rd_act & ~rd_q;
	assign wr_edge = wr_act & ~wr_q;

	////////////////////////////////////////////////////////////////////////
	// FIFOs and rate generators

	wire       tx_ready;
	wire       tx_valid;
	wire [7:0] tx_head;
	wire [5:0] tx_level;
	reg        tx_pop;
	wire       rx_ready;
	wire       rx_valid;
	wire [7:0] rx_head;
	wire [5:0] rx_level;
	wire       rx_pop;
	reg        rx_push;
	reg  [7:0] rx_word;
	wire       tx_push;
	wire       tx_gen_tick;
	wire       rx_gen_tick;
	wire       gen_en;
	reg  [2:0] tx_st_q;
	reg  [2:0] rx_st_q;

	assign tx_push = wr_edge & (addr_in[2:0] == `FUP_REG_DATA);
	assign rx_pop  = rd_edge & (addr_in[2:0] == `FUP_REG_DATA);
	// Sleep only stops the clocks once nothing is left to move
	assign gen_en = ~sleep_in | tx_valid | (tx_st_q != T_IDLE) // R17
	              | (rx_st_q != R_IDLE);

	fup_fifo #(.W(`FUP_FIFO_WIDTH), .DEPTH(`FUP_FIFO_DEPTH), // R10
	           .AW(`FUP_FIFO_AW)) u_tx_fifo (
		.clk_in        (clk_in),
		.arst_n_in     (arst_n_in),
		.in_valid_in   (tx_push),
		.in_data_in    (data_in),
		.in_ready_out  (tx_ready),
		.out_valid_out (tx_valid),
		.out_data_out  (tx_head),
		.out_ready_in  (tx_pop),
		.level_out     (tx_level)
	);

	fup_fifo #(.W(`FUP_FIFO_WIDTH), .DEPTH(`FUP_FIFO_DEPTH), // R10
	           .AW(`FUP_FIFO_AW)) u_rx_fifo (
		.clk_in        (clk_in),
		.arst_n_in     (arst_n_in),
		.in_valid_in   (rx_push),
		.in_data_in    (rx_word),
		.in_ready_out  (rx_ready),
		.out_valid_out (rx_valid),
		.out_data_out  (rx_head),
		.out_ready_in  (rx_pop),
		.level_out     (rx_level)
	);

	fup_rate_gen u_tx_gen (
		.clk_in       (clk_in),
		.arst_n_in    (arst_n_in),
		.en_in        (gen_en),
		.prescale4_in (prescale4_in),
		.divisor_in   (tx_divisor_in),
		.tick_out     (tx_gen_tick)
	);

	fup_rate_gen u_rx_gen (
		.clk_in       (clk_in),
		.arst_n_in    (arst_n_in),
		.en_in        (gen_en),
		.prescale4_in (prescale4_in),
		.divisor_in   (rx_divisor_in),
		.tick_out     (rx_gen_tick)
	);

	// External receive clock is an ordinary input, used by its rising edge
	reg  rclk_q;
	wire rx_tick;
	assign rx_tick = (pc_mode | ~ext_rx_clk_en_in) ? rx_gen_tick // R3
	                                               : (rclk_in & ~rclk_q); // R1

	////////////////////////////////////////////////////////////////////////
	// Transmitter

	reg  [3:0] tx_cnt_q;
	reg  [2:0] tx_bit_q;
	reg  [7:0] tx_sh_q;
	reg        tx_par_q;
	reg        tx_stop2_q;
	reg        xoff_hold_q;
	reg        tx_line;
	wire       tx_go;
	wire       tx_bit_end;

	// Flow control holds only before a new character, never mid-frame
	assign tx_go = tx_valid & ~(auto_cts_en_in & cts_n_in) // R20
	             & ~(sw_flow_en_in & xoff_hold_q); // R15
	assign tx_bit_end = tx_gen_tick & (tx_cnt_q == `FUP_SAMPLE_LAST); // R12

	always @* begin
		case (tx_st_q)
		T_START: tx_line = 1'b0; // R22
		T_DATA:  tx_line = tx_sh_q[0]; // R22
		T_PAR:   tx_line = tx_par_q; // R9
		default: tx_line = 1'b1;
		endcase
	end

	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_st_q    <= T_IDLE;
			tx_cnt_q   <= 4'h0;
			tx_bit_q   <= 3'h0;
			tx_sh_q    <= 8'h00;
			tx_par_q   <= 1'b0;
			tx_stop2_q <= 1'b0;
			tx_pop     <= 1'b0;
		end else begin
			tx_pop <= 1'b0;
			if (tx_gen_tick && tx_st_q != T_IDLE)
				tx_cnt_q <= tx_cnt_q + 4'h1;
			case (tx_st_q)
			T_IDLE: begin
				// Start on a tick so the start bit spans sixteen full ticks
				if (tx_go && !tx_pop && tx_gen_tick) begin
					tx_sh_q  <= tx_head; // R8
					tx_par_q <= ^tx_head ^ ~parity_even_in; // R9
					tx_pop   <= 1'b1;
					tx_cnt_q <= 4'h0;
					tx_st_q  <= T_START;
				end
			end
			T_START: begin
				if (tx_bit_end) begin
					tx_bit_q <= 3'h0;
					tx_st_q  <= T_DATA;
				end
			end
			T_DATA: begin
				if (tx_bit_end) begin
					tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
					tx_bit_q <= tx_bit_q + 3'h1;
					if (tx_bit_q == 3'h7)
						tx_st_q <= parity_en_in ? T_PAR : T_STOP; // R9
					tx_stop2_q <= stop2_in;
				end
			end
			T_PAR: begin
				if (tx_bit_end)
					tx_st_q <= T_STOP;
			end
			T_STOP: begin
				if (tx_bit_end) begin
					tx_stop2_q <= 1'b0;
					if (!tx_stop2_q)
						tx_st_q <= T_IDLE; // R8
				end
			end
			default: tx_st_q <= T_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver

	reg  [3:0] rx_cnt_q;
	reg  [2:0] rx_bit_q;
	reg  [7:0] rx_sh_q;
	reg  [4:0] ir_stretch_q;
	reg        rx_line_q;
	reg        perr_q;
	reg        ferr_q;
	reg        ovr_q;
	reg        spec_q;
	reg        par_bad_q;
	wire       rx_smp;
	wire       st_clr;
	wire       is_xon;
	wire       is_xoff;
	wire       flow_char;

	assign rx_smp = rx_tick & (rx_cnt_q == `FUP_SAMPLE_LAST); // R22
	assign st_clr = rd_edge & (addr_in[2:0] == `FUP_REG_STATUS);
	assign is_xon  = (rx_sh_q == xon_char_in);
	assign is_xoff = (rx_sh_q == xoff_char_in);
	assign flow_char = sw_flow_en_in & (is_xon | is_xoff);

	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_st_q      <= R_IDLE;
			rx_cnt_q     <= 4'h0;
			rx_bit_q     <= 3'h0;
			rx_sh_q      <= 8'h00;
			rx_line_q    <= 1'b1; // R7
			ir_stretch_q <= 5'h00;
			// Matches the idle level of the looped rate pin: no false edge
			rclk_q       <= 1'b1;
			rx_push      <= 1'b0;
			rx_word      <= 8'h00;
			par_bad_q    <= 1'b0;
			xoff_hold_q  <= 1'b0;
			perr_q       <= 1'b0;
			ferr_q       <= 1'b0;
			ovr_q        <= 1'b0;
			spec_q       <= 1'b0;
		end else begin
			rclk_q  <= rclk_in;
			rx_push <= 1'b0;
			// IR pulse marks a zero bit; it is held low for one bit time
			if (rxd_in)
				ir_stretch_q <= 5'h10; // R16
			else if (rx_tick && ir_stretch_q != 5'h00)
				ir_stretch_q <= ir_stretch_q - 5'h01;
			rx_line_q <= ir_mode_in ? ~(rxd_in | (ir_stretch_q != 5'h00))
			                        : rxd_in;
			if (rx_tick && rx_st_q != R_IDLE)
				rx_cnt_q <= rx_cnt_q + 4'h1;
			case (rx_st_q)
			R_IDLE: begin
				rx_cnt_q <= 4'h0;
				if (!rx_line_q)
					rx_st_q <= R_START; // R8
			end
			R_START: begin
				if (rx_tick && rx_cnt_q == `FUP_SAMPLE_MID) begin
					rx_cnt_q <= 4'h0;
					rx_bit_q <= 3'h0;
					rx_st_q  <= rx_line_q ? R_IDLE : R_DATA; // R23
				end
			end
			R_DATA: begin
				if (rx_smp) begin
					rx_sh_q  <= {rx_line_q, rx_sh_q[7:1]}; // R22
					rx_bit_q <= rx_bit_q + 3'h1;
					if (rx_bit_q == 3'h7)
						rx_st_q <= parity_en_in ? R_PAR : R_STOP;
					par_bad_q <= 1'b0;
				end
			end
			R_PAR: begin
				if (rx_smp) begin
					par_bad_q <= rx_line_q ^ ^rx_sh_q ^ ~parity_even_in; // R9
					rx_st_q   <= R_STOP;
				end
			end
			R_STOP: begin
				if (rx_smp) begin
					rx_st_q <= R_IDLE;
					rx_word <= rx_sh_q; // R8
					rx_push <= ~flow_char;
					if (sw_flow_en_in && is_xoff)
						xoff_hold_q <= 1'b1; // R15
					else if (sw_flow_en_in && is_xon)
						xoff_hold_q <= 1'b0; // R15
				end
			end
			default: rx_st_q <= R_IDLE;
			endcase
			if (!sw_flow_en_in)
				xoff_hold_q <= 1'b0;
			// Sticky status flags: a new event beats a same-cycle clear
			perr_q <= (rx_smp & (rx_st_q == R_STOP) & par_bad_q) // R9
			        | (perr_q & ~st_clr);
			ferr_q <= (rx_smp & (rx_st_q == R_STOP) & ~rx_line_q)
			        | (ferr_q & ~st_clr);
			ovr_q  <= (rx_push & ~rx_ready) | (ovr_q & ~st_clr);
			spec_q <= (rx_smp & (rx_st_q == R_STOP)
			           & (rx_sh_q == special_char_in)) // R15
			        | (spec_q & ~st_clr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Host reads, pins and interrupts

	wire irq_act;
	wire irq_en;
	wire shared_sel;

	assign irq_act = (irq_rx_en_in & (rx_level >= trig_lvl(rx_trig_sel_in))) // R13
	               | (irq_tx_en_in & (tx_level <= trig_lvl(tx_trig_sel_in))); // R13
	assign irq_en     = modem_control_reg_in[`FUP_MCR_IRQ_EN]; // R21
	assign shared_sel = com_sel_in[2];

	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin // R6
			rd_q                            <= 1'b0;
			wr_q                            <= 1'b0;
			data_out                        <= 8'h00;
			transceiver_drive_disable_n_out <= 1'b1;
			txd_out                         <= 1'b1; // R7
			rts_n_out                       <= 1'b1;
			dtr_n_out                       <= 1'b1;
			op1_n_out                       <= 1'b1;
			op2_n_out                       <= 1'b1;
			rate_gen_clock_out_n_out        <= 1'b1;
			tx_full_out                     <= 1'b0;
			shared_irq_out                  <= 1'b0;
			shared_irq_oe_out               <= 1'b0;
			com_irq_primary_out             <= 1'b0;
			com_irq_primary_oe_out          <= 1'b0;
			com_irq_secondary_out           <= 1'b0;
			com_irq_secondary_oe_out        <= 1'b0;
		end else begin
			rd_q <= rd_act;
			wr_q <= wr_act;
			transceiver_drive_disable_n_out <= ~rd_act; // R5
			if (rd_edge) begin
				case (addr_in[2:0])
				`FUP_REG_DATA:  data_out <= rx_valid ? rx_head : 8'h00;
				`FUP_REG_RXLVL: data_out <= {2'h0, rx_level};
				`FUP_REG_TXLVL: data_out <= {2'h0, tx_level};
				`FUP_REG_STATUS:
					data_out <= {xoff_hold_q, (tx_st_q == T_IDLE) & ~tx_valid,
					             tx_ready, spec_q, ferr_q, perr_q, ovr_q,
					             rx_valid};
				default: data_out <= 8'h00;
				endcase
			end
			// IR output idles low and sends a short high pulse per zero
			txd_out <= ir_mode_in ? (~tx_line & (tx_cnt_q < `FUP_IR_PULSE_LEN)) // R16
			                      : tx_line; // R19
			if (!auto_rts_en_in)
				rts_n_out <= ~modem_control_reg_in[`FUP_MCR_RTS];
			else if (rx_level >= `FUP_RTS_OFF_LVL)
				rts_n_out <= 1'b1; // R14
			else if (rx_level <= `FUP_RTS_ON_LVL)
				rts_n_out <= ~modem_control_reg_in[`FUP_MCR_RTS]; // R14
			dtr_n_out <= ~modem_control_reg_in[`FUP_MCR_DTR]; // R17
			op1_n_out <= ~modem_control_reg_in[`FUP_MCR_OP1];
			op2_n_out <= ~modem_control_reg_in[`FUP_MCR_OP2];
			rate_gen_clock_out_n_out <= pc_mode ? ~lpt1_hit // R3
			                                    : ~tx_gen_tick; // R2
			tx_full_out <= ~tx_ready;
			shared_irq_out <= irq_act;
			com_irq_primary_out   <= irq_act;
			com_irq_secondary_out <= irq_act;
			if (pc_mode) begin
				shared_irq_oe_out <= irq_en & shared_sel // R18
					& (~modem_control_reg_in[`FUP_MCR_INT_TYPE] | irq_act);
				com_irq_primary_oe_out   <= irq_en & ~shared_sel
				                          & ~com_sel_in[0]; // R18
				com_irq_secondary_oe_out <= irq_en & ~shared_sel
				                          & com_sel_in[0]; // R18
			end else begin
				shared_irq_oe_out <= ~modem_control_reg_in[`FUP_MCR_INT_TYPE]
				                   | irq_act;
				com_irq_primary_oe_out   <= 1'b0;
				com_irq_secondary_oe_out <= 1'b0;
			end
		end
	end
endmodule // fup_top

/* fup_top_chk.sv */
// Port-level assertions for the serial transceiver top
`timescale 1ns/1ps
module fup_top_chk (
	// Clock, reset and inputs
	input wire        clk_in,
	input wire        arst_n_in,
	input wire        sel_n_in,
	input wire [9:0]  addr_in,
	input wire        cs_n_in,
	input wire        rd_n_in,
	input wire        prescale4_in,
	input wire [15:0] tx_divisor_in,
	input wire        ir_mode_in,
	input wire [7:0]  modem_control_reg_in,
	// Watched outputs
	input wire [7:0]  data_out,
	input wire        transceiver_drive_disable_n_out,
	input wire        txd_out,
	input wire        rts_n_out,
	input wire        rate_gen_clock_out_n_out,
	input wire        com_irq_primary_oe_out,
	input wire        com_irq_secondary_oe_out
);
	// Cycle figures below hold only at divisor 2 without prescale
	wire fast = tx_divisor_in == 16'h0002 && !prescale4_in;
	wire lpt = addr_in[9:3] == 7'h6F;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	////////////////////////////////////////
	chk_rst_idle: assert property (disable iff (1'b0) !arst_n_in |->
		txd_out && rts_n_out && transceiver_drive_disable_n_out)
		else $error("idle levels wrong in reset");
	chk_rst_outs: assert property (disable iff (1'b0) !arst_n_in |->
		data_out == 8'h00 && rate_gen_clock_out_n_out)
		else $error("outputs not cleared in reset");
	chk_transceiver_drive_disable_n_low: assert property (sel_n_in && !cs_n_in && !rd_n_in
		|=> !transceiver_drive_disable_n_out)
		else $error("drive disable high during read");
	chk_transceiver_drive_disable_n_high: assert property (rd_n_in
		|=> transceiver_drive_disable_n_out)
		else $error("drive disable low without read");
	chk_lpt_decode: assert property (!sel_n_in
		|=> rate_gen_clock_out_n_out == !$past(lpt))
		else $error("printer decode output wrong");
	chk_baud_pulse: assert property (sel_n_in && fast &&
		$fell(rate_gen_clock_out_n_out)
		|=> rate_gen_clock_out_n_out ##1 !rate_gen_clock_out_n_out)
		else $error("rate clock pulse wrong");
	chk_bit_hold: assert property (!ir_mode_in && fast && $changed(txd_out)
		|=> $stable(txd_out)[*7])
		else $error("serial bit shorter than expected");
	chk_ir_pulse: assert property (ir_mode_in && fast && $rose(txd_out)
		|-> txd_out[*6] ##1 !txd_out)
		else $error("infrared pulse length wrong");
	chk_irq_gate: assert property (!sel_n_in && !modem_control_reg_in[3]
		|=> !com_irq_primary_oe_out && !com_irq_secondary_oe_out)
		else $error("interrupt line driven while disabled");
endmodule // fup_top_chk
bind fup_top fup_top_chk i_fup_top_chk (.clk_in, .arst_n_in, .sel_n_in,
	.addr_in, .cs_n_in, .rd_n_in, .prescale4_in, .tx_divisor_in,
	.ir_mode_in, .modem_control_reg_in, .data_out,
	.transceiver_drive_disable_n_out, .txd_out, .rts_n_out,
	.rate_gen_clock_out_n_out, .com_irq_primary_oe_out,
	.com_irq_secondary_oe_out);

/* tb_fup_top.sv */
// Host-side tests of the serial transceiver through its parallel port
`timescale 1ns/1ps
module tb_fup_top;
	reg clk_in = 1'b0, arst_n_in = 1'b1, sel_n_in = 1'b1, cs_n_in = 1'b1;
	reg rd_n_in = 1'b1, wr_n_in = 1'b1, cts_n_in = 1'b0;
	reg [2:0] com_sel_in = 3'h0;
	reg [9:0] addr_in = 10'h000;
	reg [7:0] data_in = 8'h00, modem_control_reg = 8'h03, md = 8'h80;
	reg [31:0] cf = 32'h007E1311;
	reg [15:0] div = 16'h0002;
	reg [6:0] blk = 7'h00;
	wire [7:0] data_out, far_byte;
	wire transceiver_drive_disable_n, txd, rts_n, rgc, full, dtr_n;
	integer far_cnt, i, j, fail_count = 0, checks_done = 0;
	// Receiver clock is looped from the rate pin, data from the line
	fup_top i_fup_top (.clk_in, .arst_n_in, .sel_n_in, .com_sel_in,
		.addr_in, .cs_n_in, .rd_n_in, .wr_n_in, .data_in, .data_out,
		.transceiver_drive_disable_n_out(transceiver_drive_disable_n), .parity_en_in(md[0]),
		.parity_even_in(md[1]), .stop2_in(md[2]), .prescale4_in(md[3]),
		.tx_divisor_in(div), .rx_divisor_in(div), .ext_rx_clk_en_in(md[7]),
		.ir_mode_in(md[4]), .sleep_in(cf[28]), .tx_trig_sel_in(cf[25:24]),
		.rx_trig_sel_in(cf[27:26]), .irq_tx_en_in(cf[29]),
		.irq_rx_en_in(cf[30]), .modem_control_reg_in(modem_control_reg),
		.auto_cts_en_in(md[5]), .auto_rts_en_in(md[6]),
		.sw_flow_en_in(cf[31]), .xon_char_in(cf[7:0]),
		.xoff_char_in(cf[15:8]), .special_char_in(cf[23:16]),
		.rxd_in(txd), .rclk_in(rgc), .cts_n_in, .txd_out(txd),
		.rts_n_out(rts_n), .dtr_n_out(dtr_n), .op1_n_out(), .op2_n_out(),
		.rate_gen_clock_out_n_out(rgc), .tx_full_out(full),
		.shared_irq_out(), .shared_irq_oe_out(), .com_irq_primary_out(),
		.com_irq_primary_oe_out(), .com_irq_secondary_out(),
		.com_irq_secondary_oe_out());
	fup_line_model i_fup_line_model (.clk_in, .txd_in(txd),
		.byte_out(far_byte), .count_out(far_cnt));
	////////////////////////////////////////
	initial forever #2 clk_in = ~clk_in;
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", checks_done, fail_count);
			if (fail_count == 0 && checks_done > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("unexpected %s: expected %h, seen %h", n, e, g);
			end
		end
	endtask
	task wr(input [2:0] o, input [7:0] d);
		begin
			@(posedge clk_in);
			addr_in <= {blk, o};
			data_in <= d;
			cs_n_in <= 1'b0;
			wr_n_in <= 1'b0;
			@(posedge clk_in);
			cs_n_in <= 1'b1;
			wr_n_in <= 1'b1;
			@(posedge clk_in);
		end
	endtask
	task rd(input [2:0] o, input [7:0] e, input string n);
		begin
			@(posedge clk_in);
			addr_in <= {blk, o};
			cs_n_in <= 1'b0;
			rd_n_in <= 1'b0;
			@(posedge clk_in);
			@(negedge clk_in);
			cmp(n, e, data_out);
			cmp("drive disable", 8'h00, {7'h00, transceiver_drive_disable_n});
			@(posedge clk_in);
			cs_n_in <= 1'b1;
			rd_n_in <= 1'b1;
			@(posedge clk_in);
		end
	endtask
	// Bounded wait for the far end, then room for the stop bit
	task wait_far(input integer n);
		begin
			for (j = 0; j < 20000 && far_cnt != n; j = j + 1)
				@(posedge clk_in);
			repeat (100) @(posedge clk_in);
		end
	endtask
	initial begin
		#300000;
		fail_count = fail_count + 1;
		print_verdict;
	end
	initial begin
		// A real falling edge so the asynchronous reset takes hold at once
		#1 arst_n_in = 1'b0;
		repeat (10) @(posedge clk_in);
		@(negedge clk_in);
		cmp("txd in reset", 8'h01, {7'h00, txd});
		cmp("transceiver_drive_disable_n in reset", 8'h01, {7'h00, transceiver_drive_disable_n});
		@(posedge clk_in) arst_n_in <= 1'b1;
		wr(3'h0, 8'hA5);
		wait_far(1);
		cmp("far byte", 8'hA5, far_byte);
		rd(3'h1, 8'h01, "rx level");
		rd(3'h0, 8'hA5, "rx data");
		rd(3'h3, 8'h00, "unmapped");
		rd(3'h5, 8'h60, "status");
		md <= 8'h83;
		wr(3'h0, 8'h3C);
		wait_far(2);
		rd(3'h0, 8'h3C, "parity data");
		rd(3'h5, 8'h60, "parity status");
		md <= 8'hE0;
		cts_n_in <= 1'b1;
		repeat (8) @(posedge clk_in);
		for (i = 0; i < 33; i = i + 1) wr(3'h0, i[7:0]);
		repeat (700) @(posedge clk_in);
		cmp("far count", 8'h02, far_cnt[7:0]);
		rd(3'h2, 8'h20, "tx level");
		cmp("tx full", 8'h01, {7'h00, full});
		cts_n_in <= 1'b0;
		wait_far(34);
		cmp("far last", 8'h1F, far_byte);
		cmp("rts off", 8'h01, {7'h00, rts_n});
		rd(3'h1, 8'h20, "rx full level");
		for (i = 0; i < 32; i = i + 1) rd(3'h0, i[7:0], "rx fifo");
		cmp("rts on", 8'h00, {7'h00, rts_n});
		cmp("dtr", 8'h00, {7'h00, dtr_n});
		sel_n_in <= 1'b0;
		blk <= 7'h7F;
		rd(3'h5, 8'h60, "pc status");
		addr_in <= 10'h378;
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		cmp("printer decode", 8'h00, {7'h00, rgc});
		@(posedge clk_in);
		addr_in <= 10'h000;
		sel_n_in <= 1'b1;
		blk <= 7'h00;
		md <= 8'h90;
		wr(3'h0, 8'h0F);
		repeat (600) @(posedge clk_in);
		rd(3'h0, 8'h0F, "ir data");
		cmp("ir idle", 8'h00, {7'h00, txd});
		print_verdict;
	end
endmodule // tb_fup_top
